// ---- rtl/rvrb_params.svh ----
`ifndef RVRB_PARAMS_SVH
`define RVRB_PARAMS_SVH

// Bank shape and bus geometry
`define RVRB_NREG      16
`define RVRB_AW        7
`define RVRB_AW_MAX    10
`define RVRB_OPT_W     3

// Entry order, 15 down to 0: flagsA wakeB wakeA edgeSel modeCtl dirB dirA
// portD portC portB portA pointer status pcLow bankSel indirect
`define RVRB_OFFSETS   {8'h14, 8'h12, 8'h10, 8'h0f, 8'h0e, 8'h0c, 8'h0b, 8'h08, \
                        8'h07, 8'h06, 8'h05, 8'h04, 8'h03, 8'h02, 8'h01, 8'h00}
`define RVRB_POR_VALS  {8'h00, 8'h00, 8'h00, 8'h3f, 8'hc0, 8'h3f, 8'h1f, 8'h00, \
                        8'h00, 8'h00, 8'h00, 8'hff, 8'h18, 8'h00, 8'h00, 8'h00}
`define RVRB_PIN_KEEP  {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, \
                        8'h00, 8'h00, 8'h00, 8'hff, 8'h67, 8'h00, 8'h00, 8'hff}
`define RVRB_WAKE_KEEP {8'h7f, 8'hb1, 8'h7c, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, \
                        8'hfc, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h11, 8'hff}
`define RVRB_OPT_MASK  {8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00, \
                        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}
`define RVRB_SW_WMASK  {8'h7f, 8'hff, 8'hfc, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, \
                        8'hfc, 8'hff, 8'hff, 8'hff, 8'he7, 8'hff, 8'h11, 8'hff}

// Entry indices
`define RVRB_I_IND     4'h0
`define RVRB_I_BANK    4'h1
`define RVRB_I_PCLO    4'h2
`define RVRB_I_STS     4'h3
`define RVRB_I_PTR     4'h4
`define RVRB_I_PA      4'h5
`define RVRB_I_PB      4'h6
`define RVRB_I_PC      4'h7
`define RVRB_I_PD      4'h8
`define RVRB_I_DIRA    4'h9
`define RVRB_I_DIRB    4'ha
`define RVRB_I_MODE    4'hb
`define RVRB_I_EDGE    4'hc
`define RVRB_I_WUA     4'hd
`define RVRB_I_WUB     4'he
`define RVRB_I_SFA     4'hf

// Status bit positions
`define RVRB_INT_BIT   3'h7
`define RVRB_T_BIT     3'h4
`define RVRB_P_BIT     3'h3

// Bus responses
`define RVRB_RESP_OK   2'h0
`define RVRB_RESP_ERR  2'h2

`endif

// ---- rtl/rvrb_pkg.sv ----
`include "rvrb_params.svh"

package rvrb_pkg;

	typedef logic [`RVRB_NREG-1:0][7:0] rvrb_regs_t;

	typedef enum logic [1:0] {
		EV_NONE = 2'h0,
		EV_POR  = 2'h1,
		EV_PIN  = 2'h2,
		EV_WAKE = 2'h3
	} rvrb_event_t;

	typedef struct packed {
		rvrb_regs_t regs;
	} rvrb_bank_state_t;

endpackage

// ---- rtl/rvrb_reset_policy.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "rvrb_params.svh"

module rvrb_reset_policy
	import rvrb_pkg::*;
(
	input  wire logic [`RVRB_OPT_W-1:0] option,
	input  wire rvrb_event_t            evKind,
	input  wire rvrb_regs_t             cur,
	output var  rvrb_regs_t             loaded
);

	localparam rvrb_regs_t POR_V  = `RVRB_POR_VALS; // R2 R3 R4 R6 R7 R8 R9 R10 R11 R12 R13 R15 R16 R17 R18 R19
	localparam rvrb_regs_t PIN_K  = `RVRB_PIN_KEEP; // R1 R4 R6
	localparam rvrb_regs_t WAKE_K = `RVRB_WAKE_KEEP; // R1 R2 R3 R7 R8 R9 R10 R11 R12 R13 R15 R16 R17 R18
	localparam rvrb_regs_t OPT_M  = `RVRB_OPT_MASK; // R13 R14

	////////////////////////////////////////////////////////////////
	// Per entry load or retain
	for (genvar i = 0; i < `RVRB_NREG; i++) begin : g_ent
		logic [7:0] fixedVal;

		// Option bits come from the configuration word
		assign fixedVal = (POR_V[i] & ~OPT_M[i]) | ({5'h00, option} & OPT_M[i]); // R14

		always_comb begin
			unique case (evKind)
				EV_POR:  loaded[i] = fixedVal;
				EV_PIN:  loaded[i] = (cur[i] & PIN_K[i]) | (fixedVal & ~PIN_K[i]);
				EV_WAKE: loaded[i] = cur[i] & WAKE_K[i];
				EV_NONE: loaded[i] = cur[i];
			endcase
		end
	end

endmodule

`default_nettype wire

// ---- rtl/rvrb_axil_slave.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "rvrb_params.svh"

module rvrb_axil_slave #(
	parameter int ADDR_W = `RVRB_AW
) (
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	output logic                   wrEn,
	output logic [ADDR_W-1:0]      wrAddr,
	output logic [7:0]             wrData,
	input  wire logic              wrHit,
	output logic [ADDR_W-1:0]      rdAddr,
	input  wire logic [7:0]        rdData,
	input  wire logic              rdHit
);

	typedef struct packed {
		logic              awRdy;
		logic              wRdy;
		logic [ADDR_W-1:0] awAddr;
		logic [7:0]        wData;
		logic              wLane0;
		logic              bValid;
		logic [1:0]        bResp;
		logic              arRdy;
		logic              rValid;
		logic [31:0]       rData;
		logic [1:0]        rResp;
	} rvrb_slv_state_t;

	rvrb_slv_state_t s;
	rvrb_slv_state_t next_s;
	logic            wrGo;

	////////////////////////////////////////////////////////////////
	// Channel handshakes
	always_comb begin
		next_s = s;
		wrGo = 1'b0;
		if (s.awRdy && awvalid) begin
			next_s.awRdy = 1'b0;
			next_s.awAddr = awaddr;
		end
		if (s.wRdy && wvalid) begin
			next_s.wRdy = 1'b0;
			next_s.wData = wdata[7:0];
			next_s.wLane0 = wstrb[0];
		end
		// Both halves held: commit and answer
		if (!s.awRdy && !s.wRdy && !s.bValid) begin
			wrGo = 1'b1;
			next_s.bValid = 1'b1;
			next_s.bResp = wrHit ? `RVRB_RESP_OK : `RVRB_RESP_ERR;
		end
		if (s.bValid && bready) begin
			next_s.bValid = 1'b0;
			next_s.awRdy = 1'b1;
			next_s.wRdy = 1'b1;
		end
		if (s.arRdy && arvalid) begin
			next_s.arRdy = 1'b0;
			next_s.rValid = 1'b1;
			next_s.rData = {24'h000000, rdData};
			next_s.rResp = rdHit ? `RVRB_RESP_OK : `RVRB_RESP_ERR;
		end
		if (s.rValid && rready) begin
			next_s.rValid = 1'b0;
			next_s.arRdy = 1'b1;
		end
		if (rst) begin
			next_s = '0;
			next_s.awRdy = 1'b1;
			next_s.wRdy = 1'b1;
			next_s.arRdy = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		s <= next_s;
	end

	assign awready = s.awRdy;
	assign wready = s.wRdy;
	assign bvalid = s.bValid;
	assign bresp = s.bResp;
	assign arready = s.arRdy;
	assign rvalid = s.rValid;
	assign rdata = s.rData;
	assign rresp = s.rResp;
	// Lane 0 carries the whole 8-bit register
	assign wrEn = wrGo && s.wLane0;
	assign wrAddr = s.awAddr;
	assign wrData = s.wData;
	assign rdAddr = araddr;

endmodule

`default_nettype wire

// ---- rtl/rvrb_reg_bank.sv ----
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "rvrb_params.svh"

// Summary of operation
// R1: Indirect access port undefined at power-on, kept on pin, watchdog or wake.
// R2: Bank select clears on resets; wake keeps only bits 4 and 0.
// R3: Program counter low clears on resets, kept across wake-up.
// R4: Interrupt bit clears; T and P set at power-on; arithmetic flags retained.
// R5: After pin, watchdog or wake, T and P follow the cause.
// R6: Indirect pointer loads all ones at power-on, kept otherwise.
// R7: Port A data clears on resets, kept across wake-up.
// R8: Port B data clears on resets, kept across wake-up.
// R9: Port C bits 7..2 clear on resets, kept on wake; bits 1..0 absent.
// R10: Port D data clears on resets, kept across wake-up.
// R11: Port A direction loads bits 4..0 ones, 7..5 zeros; kept on wake.
// R12: Port B direction loads bits 5..0 ones, 7..6 zeros; kept on wake.
// R13: Mode control sets bits 7,6, clears 5..3, loads 2..0 from option.
// R14: Option-marked bits load from the configuration word.
// R15: Edge select loads bits 5..0 ones, 7..6 zeros; kept on wake.
// R16: Wake control A bits 7..2 clear on resets; wake clears bit 7 only.
// R17: Wake control B clears on resets; wake keeps bits 7,5,4,0.
// R18: Flags A bits 6..0 clear on resets, kept on wake; bit 7 undefined.
// R19: Undefined bits carry no guaranteed value.
// R20: Power-on, pin, watchdog and low-voltage events all reset the bank.
// R21: Watchdog clears T; sleep wake sets T clears P; pin run keeps both.
// R22: Each event applies its policy on the edge it is seen.
////////////////////////////////////////////////////////////////

module rvrb_reg_bank
	import rvrb_pkg::*;
#(
	parameter int ADDR_W = `RVRB_AW
) (
	input  wire logic                   clock,
	input  wire logic                   rst,
	input  wire logic                   porEvent,
	input  wire logic                   lowVoltEvent,
	input  wire logic                   pinWdogEvent,
	input  wire logic                   watchdogCause,
	input  wire logic                   inSleep,
	input  wire logic                   wakeEvent,
	input  wire logic                   wdogClearCmd,
	input  wire logic                   sleepCmd,
	input  wire logic [`RVRB_OPT_W-1:0] oscModeOption,
	input  wire logic [ADDR_W-1:0]      awaddr,
	input  wire logic                   awvalid,
	output logic                        awready,
	input  wire logic [31:0]            wdata,
	input  wire logic [3:0]             wstrb,
	input  wire logic                   wvalid,
	output logic                        wready,
	output logic [1:0]                  bresp,
	output logic                        bvalid,
	input  wire logic                   bready,
	input  wire logic [ADDR_W-1:0]      araddr,
	input  wire logic                   arvalid,
	output logic                        arready,
	output logic [31:0]                 rdata,
	output logic [1:0]                  rresp,
	output logic                        rvalid,
	input  wire logic                   rready,
	output var  rvrb_regs_t             regsOut
);

	localparam rvrb_regs_t OFFS   = `RVRB_OFFSETS;
	localparam rvrb_regs_t POR_V  = `RVRB_POR_VALS;
	localparam rvrb_regs_t PIN_K  = `RVRB_PIN_KEEP;
	localparam rvrb_regs_t WAKE_K = `RVRB_WAKE_KEEP;
	localparam rvrb_regs_t SW_M   = `RVRB_SW_WMASK;

	if (ADDR_W < `RVRB_AW || ADDR_W > `RVRB_AW_MAX) begin : g_bad_aw
		$error("ADDR_W outside the decodable range");
	end

	rvrb_bank_state_t  st;
	rvrb_bank_state_t  next_st;
	rvrb_regs_t        rg;
	rvrb_regs_t        loaded;
	rvrb_event_t       evKind;
	logic              isPor;
	logic              isPin;
	logic              isWake;
	logic              wrEn;
	logic [ADDR_W-1:0] wrAddr;
	logic [7:0]        wrData;
	logic [ADDR_W-1:0] rdAddr;
	logic [7:0]        rdData;
	logic [4:0]        wrDec;
	logic [4:0]        rdDec;

	assign rg = st.regs;

	////////////////////////////////////////////////////////////////
	// Address decode: word aligned, hit flag over index
	function automatic logic [4:0] decode(input logic [ADDR_W-1:0] a);
		logic [4:0] r;
		r = '0;
		for (int k = 0; k < `RVRB_NREG; k++) begin
			if (a[1:0] == '0 && 8'(a >> 2) == OFFS[k]) begin
				r = {1'b1, 4'(k)};
			end
		end
		return r;
	endfunction

	assign wrDec = decode(wrAddr);
	assign rdDec = decode(rdAddr);
	assign rdData = rdDec[4] ? rg[rdDec[3:0]] : 8'h00;

	////////////////////////////////////////////////////////////////
	// Bus slave
	rvrb_axil_slave #(
		.ADDR_W (ADDR_W)
	) u_slave (
		.clock   (clock),
		.rst     (rst),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.wrEn    (wrEn),
		.wrAddr  (wrAddr),
		.wrData  (wrData),
		.wrHit   (wrDec[4]),
		.rdAddr  (rdAddr),
		.rdData  (rdData),
		.rdHit   (rdDec[4])
	);

	////////////////////////////////////////////////////////////////
	// Event qualification, strongest first
	assign isPor = rst || porEvent || lowVoltEvent; // R20
	assign isPin = !isPor && pinWdogEvent; // R20
	assign isWake = !isPor && !pinWdogEvent && wakeEvent;

	always_comb begin
		if (isPor) begin
			evKind = EV_POR;
		end else if (isPin) begin
			evKind = EV_PIN;
		end else if (isWake) begin
			evKind = EV_WAKE;
		end else begin
			evKind = EV_NONE;
		end
	end

	// Per-bit load and retain tables
	rvrb_reset_policy u_policy (
		.option (oscModeOption),
		.evKind (evKind),
		.cur    (rg),
		.loaded (loaded)
	);

	////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		next_st = st;
		next_st.regs = loaded; // R22
		// Software loses to any reset event in the same cycle
		if (evKind == EV_NONE && wrEn && wrDec[4]) begin
			next_st.regs[wrDec[3:0]] = (rg[wrDec[3:0]] & ~SW_M[wrDec[3:0]]) | (wrData & SW_M[wrDec[3:0]]);
		end
		unique case (evKind)
			EV_POR: begin
			end
			EV_PIN: begin
				// Watchdog clears T; pin wake from sleep sets it; else kept
				next_st.regs[`RVRB_I_STS][`RVRB_T_BIT] =
					!watchdogCause && (inSleep || rg[`RVRB_I_STS][`RVRB_T_BIT]); // R5 R21
				next_st.regs[`RVRB_I_STS][`RVRB_P_BIT] =
					!inSleep && rg[`RVRB_I_STS][`RVRB_P_BIT]; // R5 R21
			end
			EV_WAKE: begin
				next_st.regs[`RVRB_I_STS][`RVRB_T_BIT] = 1'b1; // R5 R21
				next_st.regs[`RVRB_I_STS][`RVRB_P_BIT] = 1'b0; // R5 R21
			end
			EV_NONE: begin
				if (wdogClearCmd) begin
					next_st.regs[`RVRB_I_STS][`RVRB_T_BIT] = 1'b1;
					next_st.regs[`RVRB_I_STS][`RVRB_P_BIT] = 1'b1;
				end else if (sleepCmd) begin
					next_st.regs[`RVRB_I_STS][`RVRB_T_BIT] = 1'b1;
					next_st.regs[`RVRB_I_STS][`RVRB_P_BIT] = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge clock) begin
		st <= next_st;
	end

	assign regsOut = st.regs;

	////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	ind_keep_a: assert property ( // R1
		(isPin || isWake) |=> rg[`RVRB_I_IND] == $past(rg[`RVRB_I_IND])
	) else $error("indirect access port not kept");

	bank_clear_a: assert property ( // R2
		isPin |=> rg[`RVRB_I_BANK] == POR_V[`RVRB_I_BANK]
	) else $error("bank select not cleared");

	bank_wake_a: assert property ( // R2
		isWake |=> rg[`RVRB_I_BANK] == ($past(rg[`RVRB_I_BANK]) & WAKE_K[`RVRB_I_BANK])
	) else $error("bank select wake policy wrong");

	pclo_policy_a: assert property ( // R3
		isPin ##1 isWake |=> rg[`RVRB_I_PCLO] == POR_V[`RVRB_I_PCLO]
	) else $error("program counter low not cleared then kept");

	sts_pin_a: assert property ( // R4
		isPin |=> !rg[`RVRB_I_STS][`RVRB_INT_BIT]
			&& (rg[`RVRB_I_STS] & PIN_K[`RVRB_I_STS]) == ($past(rg[`RVRB_I_STS]) & PIN_K[`RVRB_I_STS])
	) else $error("status pin policy wrong");

	wdog_flags_a: assert property ( // R5
		isPin && watchdogCause |=> !rg[`RVRB_I_STS][`RVRB_T_BIT]
			&& rg[`RVRB_I_STS][`RVRB_P_BIT] == (!$past(inSleep) && $past(rg[`RVRB_I_STS][`RVRB_P_BIT]))
	) else $error("watchdog flags wrong");

	pin_flags_a: assert property ( // R21
		isPin && !watchdogCause && !inSleep |=> $stable(rg[`RVRB_I_STS][`RVRB_T_BIT:`RVRB_P_BIT])
	) else $error("pin reset in run changed flags");

	sleep_flags_a: assert property ( // R21
		(isWake || (isPin && !watchdogCause && inSleep)) |=>
			rg[`RVRB_I_STS][`RVRB_T_BIT] && !rg[`RVRB_I_STS][`RVRB_P_BIT]
	) else $error("sleep wake flags wrong");

	ptr_por_a: assert property ( // R6
		porEvent |=> rg[`RVRB_I_PTR] == POR_V[`RVRB_I_PTR] && rg[`RVRB_I_STS][`RVRB_T_BIT]
	) else $error("pointer not loaded at power-on");

	ptr_keep_a: assert property ( // R6
		(isPin || isWake) |=> $stable(rg[`RVRB_I_PTR])
	) else $error("pointer not kept");

	low_volt_a: assert property ( // R20
		lowVoltEvent |=> rg[`RVRB_I_DIRA] == POR_V[`RVRB_I_DIRA] && rg[`RVRB_I_PA] == POR_V[`RVRB_I_PA]
	) else $error("low voltage did not reset");

	port_keep_a: assert property ( // R7 R8 R10
		isWake |=> $stable(rg[`RVRB_I_PA]) && $stable(rg[`RVRB_I_PB]) && $stable(rg[`RVRB_I_PD])
	) else $error("port data not kept on wake");

	port_clear_a: assert property ( // R7 R8 R9 R10
		isPin |=> rg[`RVRB_I_PA] == '0 && rg[`RVRB_I_PB] == '0
			&& rg[`RVRB_I_PC][7:2] == '0 && rg[`RVRB_I_PD] == '0
	) else $error("port data not cleared");

	dir_load_a: assert property ( // R11 R12
		isPin |=> rg[`RVRB_I_DIRA] == POR_V[`RVRB_I_DIRA] && rg[`RVRB_I_DIRB] == POR_V[`RVRB_I_DIRB]
	) else $error("direction defaults wrong");

	mode_load_a: assert property ( // R13 R14
		isPin |=> rg[`RVRB_I_MODE][7:3] == POR_V[`RVRB_I_MODE][7:3]
			&& rg[`RVRB_I_MODE][`RVRB_OPT_W-1:0] == $past(oscModeOption)
	) else $error("mode control load wrong");

	edge_load_a: assert property ( // R15
		isPin |=> rg[`RVRB_I_EDGE] == POR_V[`RVRB_I_EDGE]
	) else $error("edge select defaults wrong");

	wua_wake_a: assert property ( // R16
		isWake |=> !rg[`RVRB_I_WUA][7] && rg[`RVRB_I_WUA][6:2] == $past(rg[`RVRB_I_WUA][6:2])
	) else $error("wake control A wake policy wrong");

	wub_wake_a: assert property ( // R17
		isWake |=> rg[`RVRB_I_WUB] == ($past(rg[`RVRB_I_WUB]) & WAKE_K[`RVRB_I_WUB])
	) else $error("wake control B wake policy wrong");

	sfa_policy_a: assert property ( // R18
		isPin ##1 isWake |=> rg[`RVRB_I_SFA][6:0] == '0
	) else $error("flags A policy wrong");

	write_lost_a: assert property ( // R22
		wrEn && wrDec[4] && isPin && wrDec[3:0] == `RVRB_I_PA |=> rg[`RVRB_I_PA] == '0
	) else $error("write overrode reset event");

	pclo_clear_a: assert property ( // R3
		isPin |=> rg[`RVRB_I_PCLO] == POR_V[`RVRB_I_PCLO]
	) else $error("program counter low not cleared");

	pclo_keep_a: assert property ( // R3
		isWake |=> $stable(rg[`RVRB_I_PCLO])
	) else $error("program counter low not kept");

	portc_wake_a: assert property ( // R9
		isWake |=> rg[`RVRB_I_PC][7:2] == $past(rg[`RVRB_I_PC][7:2])
	) else $error("port C not kept on wake");

	ctrl_keep_a: assert property ( // R11 R12 R13 R15
		isWake |=> $stable(rg[`RVRB_I_DIRA]) && $stable(rg[`RVRB_I_DIRB])
			&& $stable(rg[`RVRB_I_MODE]) && $stable(rg[`RVRB_I_EDGE])
	) else $error("control registers not kept on wake");

	wake_clear_a: assert property ( // R16 R17 R18
		isPin |=> rg[`RVRB_I_WUA][7:2] == '0 && rg[`RVRB_I_WUB] == '0 && rg[`RVRB_I_SFA][6:0] == '0
	) else $error("wake control or flags not cleared");

	sfa_keep_a: assert property ( // R18
		isWake |=> rg[`RVRB_I_SFA][6:0] == $past(rg[`RVRB_I_SFA][6:0])
	) else $error("flags A not kept on wake");

	por_load_a: assert property ( // R14 R20
		(porEvent || lowVoltEvent) |=> rg[`RVRB_I_BANK] == '0 && rg[`RVRB_I_STS] == POR_V[`RVRB_I_STS]
			&& rg[`RVRB_I_MODE][`RVRB_OPT_W-1:0] == $past(oscModeOption)
	) else $error("power-on load wrong");

	cmd_flags_a: assert property (
		evKind == EV_NONE && wdogClearCmd |=> rg[`RVRB_I_STS][`RVRB_T_BIT] && rg[`RVRB_I_STS][`RVRB_P_BIT]
	) else $error("watchdog clear flags wrong");

	read_hold_a: assert property (
		rvalid && !rready |=> rvalid && $stable(rdata)
	) else $error("read answer dropped");

	por_seen_c: cover property (porEvent ##1 !porEvent);
	wdog_sleep_c: cover property (isPin && watchdogCause && inSleep);
	wake_c: cover property (isWake ##[1:4] isPin);
	write_c: cover property (wrEn && wrDec[4] && evKind == EV_NONE);
	pin_wake_c: cover property (isPin ##1 isWake);

endmodule

`default_nettype wire

// ---- verification/rvrb_bus_master.sv ----
`timescale 1ns/10ps
`default_nettype none

module rvrb_bus_master #(
	parameter int ADDR_W = 7
) (
	input  wire logic              clock,
	output logic [ADDR_W-1:0]      awaddr,
	output logic                   awvalid,
	input  wire logic              awready,
	output logic [31:0]            wdata,
	output logic [3:0]             wstrb,
	output logic                   wvalid,
	input  wire logic              wready,
	input  wire logic [1:0]        bresp,
	input  wire logic              bvalid,
	output logic                   bready,
	output logic [ADDR_W-1:0]      araddr,
	output logic                   arvalid,
	input  wire logic              arready,
	input  wire logic [31:0]       rdata,
	input  wire logic [1:0]        rresp,
	input  wire logic              rvalid,
	output logic                   rready
);
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
	end

	// Released address and data show the inverse, never the stale value
	task automatic write(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [3:0] s,
			output logic [1:0] r, output bit ok);
		ok = 1'b0;
		r = 2'h3;
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 64 && !ok; n++) begin
			@(posedge clock);
			if (awvalid && awready) begin
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				wdata <= ~{24'h0, d};
			end
			if (bvalid && bready) begin
				r = bresp;
				ok = 1'b1;
				bready <= 1'b0;
			end
		end
		@(posedge clock);
	endtask

	task automatic read(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r,
			output bit ok);
		ok = 1'b0;
		d = '0;
		r = 2'h3;
		araddr <= a;
		arvalid <= 1'b1;
		// Ready follows valid by one edge, so the answer must stand
		for (int n = 0; n < 64 && !ok; n++) begin
			@(posedge clock);
			if (arvalid && arready) begin
				arvalid <= 1'b0;
				araddr <= ~a;
			end
			if (rvalid && rready) begin
				d = rdata;
				r = rresp;
				ok = 1'b1;
				rready <= 1'b0;
			end else if (rvalid) begin
				rready <= 1'b1;
			end
		end
		@(posedge clock);
	endtask
endmodule

`default_nettype wire

// ---- verification/rvrb_reg_bank_test.sv ----
`timescale 1ns/10ps
`default_nettype none

module rvrb_reg_bank_test
	import rvrb_pkg::*;
;
	typedef struct packed {logic [7:0] off, por, wm, wk, pk;} rvrb_row_t;
	typedef struct packed {logic [7:0] ev; logic [1:0] tp;} rvrb_step_t;

	logic        clock, rst, porEvent, lowVoltEvent, pinWdogEvent, watchdogCause, inSleep;
	logic        wakeEvent, wdogClearCmd, sleepCmd, awvalid, awready, wvalid, wready, bvalid;
	logic        bready, arvalid, arready, rvalid, rready;
	logic [2:0]  oscModeOption;
	logic [6:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	rvrb_regs_t  regsOut;
	logic [7:0]  model [16];
	int          compares, miscompares;

	// Columns: offset, power-on value, writable, wake keep, pin keep
	rvrb_row_t rows [16] = '{
		'{8'h00, 8'h00, 8'hff, 8'hff, 8'hff}, '{8'h01, 8'h00, 8'h11, 8'h11, 8'h00},
		'{8'h02, 8'h00, 8'hff, 8'hff, 8'h00}, '{8'h03, 8'h18, 8'he7, 8'he7, 8'h67},
		'{8'h04, 8'hff, 8'hff, 8'hff, 8'hff}, '{8'h05, 8'h00, 8'hff, 8'hff, 8'h00},
		'{8'h06, 8'h00, 8'hff, 8'hff, 8'h00}, '{8'h07, 8'h00, 8'hfc, 8'hfc, 8'h00},
		'{8'h08, 8'h00, 8'hff, 8'hff, 8'h00}, '{8'h0b, 8'h1f, 8'hff, 8'hff, 8'h00},
		'{8'h0c, 8'h3f, 8'hff, 8'hff, 8'h00}, '{8'h0e, 8'hc0, 8'hff, 8'hff, 8'h00},
		'{8'h0f, 8'h3f, 8'hff, 8'hff, 8'h00}, '{8'h10, 8'h00, 8'hfc, 8'h7c, 8'h00},
		'{8'h12, 8'h00, 8'hff, 8'hb1, 8'h00}, '{8'h14, 8'h00, 8'h7f, 8'h7f, 8'h00}};
	// Event bits: power-on, low voltage, pin/watchdog, watchdog, sleep, wake, clear, sleep cmd
	rvrb_step_t steps [9] = '{'{8'h04, 2'b10}, '{8'h20, 2'b10}, '{8'h02, 2'b11},
		'{8'h30, 2'b01}, '{8'h28, 2'b10}, '{8'h02, 2'b11}, '{8'h38, 2'b00},
		'{8'h01, 2'b10}, '{8'h80, 2'b11}};

	rvrb_reg_bank rvrb_reg_bank_inst (.clock, .rst, .porEvent, .lowVoltEvent, .pinWdogEvent,
		.watchdogCause, .inSleep, .wakeEvent, .wdogClearCmd, .sleepCmd, .oscModeOption, .awaddr,
		.awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .regsOut);
	rvrb_bus_master rvrb_bus_master_inst (.clock, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready);

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	task automatic test_done();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("*** PASS ***");
		end
		else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	function automatic logic [6:0] ba(input logic [7:0] off);
		return {off[4:0], 2'b00};
	endfunction

	function automatic logic [7:0] por(input int i);
		return (i == 11) ? {5'h18, oscModeOption} : rows[i].por;
	endfunction

	task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
		logic [1:0] r;
		bit         ok;
		rvrb_bus_master_inst.write(a, d, s, r, ok);
		if (!ok) begin
			chk(32'h0, 32'h1, "write handshake timeout");
			test_done();
		end
		chk({30'h0, r}, {30'h0, er}, "bresp");
	endtask

	task automatic rd(input logic [6:0] a, input logic [7:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		bit          ok;
		rvrb_bus_master_inst.read(a, d, r, ok);
		if (!ok) begin
			chk(32'h0, 32'h1, "read handshake timeout");
			test_done();
		end
		chk(d, {24'h0, e}, "rdata");
		chk({30'h0, r}, {30'h0, er}, "rresp");
	endtask

	// Port view first, then the bus view of every entry
	task automatic check_all();
		#1;
		for (int i = 0; i < 16; i++) begin
			chk({24'h0, regsOut[i]}, {24'h0, model[i]}, "bank entry");
		end
		@(posedge clock);
		for (int i = 0; i < 16; i++) begin
			rd(ba(rows[i].off), model[i], 2'h0);
		end
	endtask

	task automatic write_all(input logic [7:0] d);
		for (int i = 0; i < 16; i++) begin
			wr(ba(rows[i].off), d, 4'hf, 2'h0);
			model[i] = (d & rows[i].wm) | (model[i] & ~rows[i].wm);
		end
	endtask

	task automatic apply(input logic [7:0] v, input logic [1:0] tp);
		for (int i = 0; i < 16; i++) begin
			if (v[7] || v[6]) model[i] = por(i);
			else if (v[5]) model[i] = (model[i] & rows[i].pk) | (por(i) & ~rows[i].pk);
			else if (v[2]) model[i] = model[i] & rows[i].wk;
		end
		model[3][4:3] = tp;
		{porEvent, lowVoltEvent, pinWdogEvent, watchdogCause, inSleep, wakeEvent, wdogClearCmd, sleepCmd} <= v;
		@(posedge clock);
		{porEvent, lowVoltEvent, pinWdogEvent, watchdogCause, inSleep, wakeEvent, wdogClearCmd, sleepCmd} <= 8'h00;
		check_all();
	endtask

	initial begin
		compares = 0;
		miscompares = 0;
		rst = 1'b1;
		oscModeOption = 3'h5;
		{porEvent, lowVoltEvent, pinWdogEvent, watchdogCause, inSleep, wakeEvent, wdogClearCmd, sleepCmd} = 8'h00;
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		for (int i = 0; i < 16; i++) model[i] = por(i);
		check_all();
		for (int k = 0; k < 9; k++) begin
			write_all(k[0] ? 8'ha5 : 8'h5a);
			apply(steps[k].ev, steps[k].tp);
		end
		oscModeOption <= 3'h2;
		@(posedge clock);
		write_all(8'hff);
		apply(8'h40, 2'b11);
		wr(ba(8'h02), 8'h77, 4'h0, 2'h0);
		wr(7'h09, 8'h77, 4'hf, 2'h2);
		wr(ba(8'h09), 8'h77, 4'hf, 2'h2);
		rd(ba(8'h0d), 8'h00, 2'h2);
		wr(ba(8'h03), 8'h00, 4'hf, 2'h0);
		model[3] = model[3] & 8'h18;
		check_all();
		// Pin reset lands on a write, then a wake follows at once
		fork
			wr(ba(8'h05), 8'h3c, 4'hf, 2'h0);
			begin
				@(posedge clock);
				pinWdogEvent <= 1'b1;
				@(posedge clock);
				{pinWdogEvent, wakeEvent} <= 2'b01;
				@(posedge clock);
				wakeEvent <= 1'b0;
			end
		join
		for (int i = 0; i < 16; i++) model[i] = ((model[i] & rows[i].pk) | (por(i) & ~rows[i].pk)) & rows[i].wk;
		model[3][4:3] = 2'b10;
		check_all();
		write_all(8'h5a);
		rst <= 1'b1;
		@(posedge clock);
		rst <= 1'b0;
		for (int i = 0; i < 16; i++) model[i] = por(i);
		check_all();
		test_done();
	end
endmodule

`default_nettype wire
